/* File: pio_pkg.sv */
// Constants, register map and carrier types for the panel I/O stack
package pio_pkg;

  // Clock and stack geometry
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NUM_MODULES = 4;
  localparam int unsigned MAX_EXTENSIONS = 3;
  localparam int unsigned IN_BITS_PER_MODULE = 24;
  localparam int unsigned OUT_BITS_PER_MODULE = 16;
  localparam int unsigned IN_BYTES_PER_MODULE = 3;
  localparam int unsigned OUT_BYTES_PER_MODULE = 2;
  localparam int unsigned NUM_IN_BITS = NUM_MODULES * IN_BITS_PER_MODULE;
  localparam int unsigned NUM_OUT_BITS = NUM_MODULES * OUT_BITS_PER_MODULE;
  localparam int unsigned NUM_HANDWHEELS = 3;
  localparam int unsigned HW_COUNT_W = 16;

  // Handwheel timing and the sampling rate derived from it
  localparam int unsigned MIN_CYCLE_US = 200;
  localparam int unsigned MIN_QUARTER_US = 50;
  localparam int unsigned SAMPLE_PERIOD_US = 10;
  localparam int unsigned SAMPLE_CYCLES = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_CNT_W = 10;
  localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);

  // Register byte offsets
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] IN_BYTE_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] IN_BYTE_END = 12'h030;
  localparam logic [ADDR_W-1:0] OUT_BYTE_OFS = 12'h040;
  localparam logic [ADDR_W-1:0] OUT_BYTE_END = 12'h060;
  localparam logic [ADDR_W-1:0] IN_BASE_OFS = 12'h060;
  localparam logic [ADDR_W-1:0] OUT_BASE_OFS = 12'h064;
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 12'h068;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h06C;
  localparam logic [ADDR_W-1:0] HW_COUNT_OFS = 12'h070;
  localparam logic [ADDR_W-1:0] HW_COUNT_END = 12'h07C;

  // Configuration fields and reset values
  localparam int unsigned CFG_EXT_LSB = 0;
  localparam int unsigned CFG_EXT_W = 2;
  localparam int unsigned CFG_HW_EN_LSB = 4;
  localparam logic [CFG_EXT_W-1:0] CFG_EXT_RST = 2'h0;
  localparam logic [NUM_HANDWHEELS-1:0] CFG_HW_EN_RST = 3'h7;
  localparam logic [7:0] BASE_RST = 8'h00;

  // Status fields
  localparam int unsigned ST_HW_ACTIVE = 0;
  localparam int unsigned ST_EXT_LSB = 1;
  localparam int unsigned ST_COM_HIGH_LSB = 4;
  localparam int unsigned ST_COM_OPEN_LSB = 8;

  // Quarter-step accumulator limits
  localparam logic signed [2:0] QTR_HI = 3'sd3;
  localparam logic signed [2:0] QTR_LO = -3'sd3;
  localparam logic signed [2:0] QTR_ONE = 3'sd1;
  localparam logic signed [2:0] QTR_ZERO = 3'sd0;

  // Phase pair {A,B} in quadrature order
  typedef enum logic [1:0] {
    PIO_PH_00 = 2'b00,
    PIO_PH_01 = 2'b01,
    PIO_PH_11 = 2'b11,
    PIO_PH_10 = 2'b10
  } pio_phase_t;

  // APB request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } pio_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pio_apb_rsp_t;

  // Handwheel phase inputs
  typedef struct packed {
    logic [NUM_HANDWHEELS-1:0] phase_a;
    logic [NUM_HANDWHEELS-1:0] phase_b;
  } pio_hw_phase_t;

endpackage

/* File: pio_input_shaper.sv */
// Input byte conditioning for one module of the stack
module pio_input_shaper (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Module state
  input wire logic present_i,
  input wire logic common_high_i,
  input wire logic common_open_i,
  // Points and conditioned bytes
  input wire logic [23:0] point_i,
  output logic [23:0] byte_o
);

  logic [23:0] byte_q;
  logic invert;

  // First byte inverts when its common is tied high
  assign invert = common_high_i & ~common_open_i; // R6 R8

  // Absent modules read zero, fixed-common bytes pass through
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      byte_q <= 24'h000000;
    end else if (!present_i) begin
      byte_q <= 24'h000000;
    end else begin
      byte_q[7:0] <= point_i[7:0] ^ {8{invert}}; // R6 R8 R16
      byte_q[23:8] <= point_i[23:8]; // R7 R16
    end
  end

  assign byte_o = byte_q;

endmodule

/* File: pio_quad_decoder.sv */
// Quadrature decoder for one handwheel
module pio_quad_decoder (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic sample_en_i,
  input wire logic enable_i,
  // Phases
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  // Step pulse and direction
  output logic step_o,
  output logic up_o
);

  pio_pkg::pio_phase_t prev_q;
  logic signed [2:0] quarter_q;
  logic step_q;
  logic up_q;
  logic moved;
  logic up;
  logic at_end;

  // One legal quarter move: exactly one phase changed since last sample
  assign moved = sample_en_i & ((phase_a_i ^ prev_q[1]) ^ (phase_b_i ^ prev_q[0])); // R12
  assign up = phase_a_i ^ prev_q[0]; // R15
  assign at_end = up ? (quarter_q == pio_pkg::QTR_HI) : (quarter_q == pio_pkg::QTR_LO);

  // Phase history, tracked even while disabled
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_q <= pio_pkg::PIO_PH_00;
    end else if (sample_en_i) begin
      prev_q <= pio_pkg::pio_phase_t'({phase_a_i, phase_b_i});
    end
  end

  // Four quarters in one direction make one step
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quarter_q <= pio_pkg::QTR_ZERO;
    end else if (!enable_i) begin
      quarter_q <= pio_pkg::QTR_ZERO;
    end else if (moved) begin
      if (at_end) begin
        quarter_q <= pio_pkg::QTR_ZERO; // R15
      end else if (up) begin
        quarter_q <= quarter_q + pio_pkg::QTR_ONE;
      end else begin
        quarter_q <= quarter_q - pio_pkg::QTR_ONE;
      end
    end
  end

  // Registered step pulse and direction
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_q <= 1'b0;
      up_q <= 1'b0;
    end else begin
      step_q <= enable_i & moved & at_end; // R15
      if (moved) begin
        up_q <= up;
      end
    end
  end

  assign step_o = step_q;
  assign up_o = up_q;

endmodule

/* File: pio_panel_io.sv */
// Panel I/O module stack: input and output bytes, handwheels, APB registers

// Notes on behaviour
// R1 - Slave of one master; master sets addresses
// R2 - Master allows sixteen groups; stack is one
// R3 - All module bytes form one contiguous group
// R4 - Per module: three input, two output bytes
// R5 - One basic plus three extensions at most
// R6 - First input byte inverts with common high
// R7 - Unused fixed-common inputs read zero
// R8 - Unused first-byte inputs follow the common
// R9 - Master puts emergency stop in fixed bytes
// R10 - Handwheels only via first extension module
// R11 - Master uses nearest unit's handwheels only
// R12 - Three handwheels, each with phases A, B
// R13 - Two-handwheel controls ignore the third
// R14 - Cycle at least 200us, quarter 50us
// R15 - One step per cycle; direction from phase lead
// R16 - Byte bit order equals connector point order
module pio_panel_io (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire pio_pkg::pio_apb_req_t apb_req_i,
  output pio_pkg::pio_apb_rsp_t apb_rsp_o,
  // Sensed inputs and common selection, one common per module
  input wire logic [pio_pkg::NUM_IN_BITS-1:0] sensed_input_point_i,
  input wire logic [pio_pkg::NUM_MODULES-1:0] input_common_select_high_i,
  input wire logic [pio_pkg::NUM_MODULES-1:0] input_common_select_open_i,
  // Handwheel phases on the first extension module
  input wire pio_pkg::pio_hw_phase_t handwheel_phase_i,
  // Output points
  output logic [pio_pkg::NUM_OUT_BITS-1:0] output_point_o,
  // Handwheel step pulses and directions
  output logic [pio_pkg::NUM_HANDWHEELS-1:0] handwheel_step_o,
  output logic [pio_pkg::NUM_HANDWHEELS-1:0] handwheel_up_o
);

  localparam int unsigned NM = pio_pkg::NUM_MODULES;
  localparam int unsigned NH = pio_pkg::NUM_HANDWHEELS;
  localparam int unsigned IBM = pio_pkg::IN_BITS_PER_MODULE;
  localparam int unsigned OBM = pio_pkg::OUT_BITS_PER_MODULE;
  localparam int unsigned CW = pio_pkg::HW_COUNT_W;

  // Software-visible state and registered output drive
  logic [pio_pkg::NUM_OUT_BITS-1:0] out_byte_q;
  logic [pio_pkg::NUM_OUT_BITS-1:0] out_drive_q;
  logic [7:0] in_base_q;
  logic [7:0] out_base_q;
  logic [pio_pkg::CFG_EXT_W-1:0] cfg_ext_q;
  logic [NH-1:0] cfg_hw_en_q;
  logic [CW-1:0] hw_count_q [NH];

  // Conditioned inputs and presence
  logic [pio_pkg::NUM_IN_BITS-1:0] in_byte;
  logic [pio_pkg::NUM_OUT_BITS-1:0] out_mask;
  logic [NM-1:0] present;
  logic hw_active;
  logic [NH-1:0] hw_enable;
  logic [NH-1:0] step;
  logic [NH-1:0] up;

  // Sampling divider
  logic [pio_pkg::SAMPLE_CNT_W-1:0] sample_cnt_q;
  logic sample_en;

  // Bus decode
  logic access;
  logic wr;
  logic aligned;
  logic in_hit;
  logic out_hit;
  logic hw_hit;
  logic reg_hit;
  logic ro_hit;
  logic [3:0] in_idx;
  logic [2:0] out_idx;
  logic [1:0] hw_idx;
  logic [31:0] rdata;
  logic err;

  // Module k exists when k is within the extension count
  for (genvar g = 0; g < NM; g++) begin : g_module
    assign present[g] = (2'(g) <= cfg_ext_q); // R3 R5
    assign out_mask[g*OBM +: OBM] = {OBM{present[g]}}; // R4

    pio_input_shaper u_shaper (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .present_i(present[g]),
      .common_high_i(input_common_select_high_i[g]),
      .common_open_i(input_common_select_open_i[g]),
      .point_i(sensed_input_point_i[g*IBM +: IBM]),
      .byte_o(in_byte[g*IBM +: IBM]) // R3 R4
    );
  end

  // Sample tick well under the shortest quarter cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_cnt_q <= '0;
    end else if (sample_en) begin
      sample_cnt_q <= '0;
    end else begin
      sample_cnt_q <= sample_cnt_q + 1'b1;
    end
  end

  assign sample_en = (sample_cnt_q == pio_pkg::SAMPLE_LAST); // R14

  // Handwheels exist only when the first extension is fitted
  assign hw_active = (cfg_ext_q != 2'h0); // R10
  assign hw_enable = cfg_hw_en_q & {NH{hw_active}}; // R10 R13

  for (genvar h = 0; h < NH; h++) begin : g_wheel
    pio_quad_decoder u_decoder (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .sample_en_i(sample_en),
      .enable_i(hw_enable[h]),
      .phase_a_i(handwheel_phase_i.phase_a[h]),
      .phase_b_i(handwheel_phase_i.phase_b[h]),
      .step_o(step[h]),
      .up_o(up[h])
    );

    // Signed step count, wraps
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        hw_count_q[h] <= 16'h0000;
      end else if (step[h]) begin
        if (up[h]) begin
          hw_count_q[h] <= hw_count_q[h] + 16'h0001; // R12 R15
        end else begin
          hw_count_q[h] <= hw_count_q[h] - 16'h0001; // R12 R15
        end
      end
    end
  end

  assign handwheel_step_o = step;
  assign handwheel_up_o = up;

  // Address decode; every word-aligned register answers at once
  assign access = apb_req_i.psel & apb_req_i.penable; // R1
  assign wr = access & apb_req_i.pwrite & ~err;
  assign aligned = (apb_req_i.paddr[1:0] == 2'b00);
  assign in_hit = aligned & (apb_req_i.paddr < pio_pkg::IN_BYTE_END);
  assign out_hit = aligned & (apb_req_i.paddr >= pio_pkg::OUT_BYTE_OFS)
                   & (apb_req_i.paddr < pio_pkg::OUT_BYTE_END);
  assign hw_hit = aligned & (apb_req_i.paddr >= pio_pkg::HW_COUNT_OFS)
                  & (apb_req_i.paddr < pio_pkg::HW_COUNT_END);
  assign in_idx = 4'((apb_req_i.paddr - pio_pkg::IN_BYTE_OFS) >> 2);
  assign out_idx = 3'((apb_req_i.paddr - pio_pkg::OUT_BYTE_OFS) >> 2);
  assign hw_idx = 2'((apb_req_i.paddr - pio_pkg::HW_COUNT_OFS) >> 2);
  assign ro_hit = in_hit | hw_hit | (apb_req_i.paddr == pio_pkg::STATUS_OFS);
  assign reg_hit = out_hit | (apb_req_i.paddr == pio_pkg::IN_BASE_OFS)
                   | (apb_req_i.paddr == pio_pkg::OUT_BASE_OFS)
                   | (apb_req_i.paddr == pio_pkg::CONFIG_OFS);
  assign err = ~(ro_hit | reg_hit) | (apb_req_i.pwrite & ro_hit);

  // Read multiplexer, narrow fields in the low bits
  always_comb begin
    rdata = 32'h00000000;
    if (in_hit) begin
      rdata[7:0] = in_byte[{in_idx, 3'b000} +: 8]; // R3 R16
    end else if (out_hit) begin
      rdata[7:0] = out_byte_q[{out_idx, 3'b000} +: 8]; // R16
    end else if (hw_hit) begin
      rdata[CW-1:0] = hw_count_q[hw_idx];
    end else if (apb_req_i.paddr == pio_pkg::IN_BASE_OFS) begin
      rdata[7:0] = in_base_q;
    end else if (apb_req_i.paddr == pio_pkg::OUT_BASE_OFS) begin
      rdata[7:0] = out_base_q;
    end else if (apb_req_i.paddr == pio_pkg::CONFIG_OFS) begin
      rdata[pio_pkg::CFG_EXT_LSB +: pio_pkg::CFG_EXT_W] = cfg_ext_q;
      rdata[pio_pkg::CFG_HW_EN_LSB +: NH] = cfg_hw_en_q;
    end else if (apb_req_i.paddr == pio_pkg::STATUS_OFS) begin
      rdata[pio_pkg::ST_HW_ACTIVE] = hw_active;
      rdata[pio_pkg::ST_EXT_LSB +: pio_pkg::CFG_EXT_W] = cfg_ext_q;
      rdata[pio_pkg::ST_COM_HIGH_LSB +: NM] = input_common_select_high_i;
      rdata[pio_pkg::ST_COM_OPEN_LSB +: NM] = input_common_select_open_i;
    end
  end

  // Zero-wait answer
  always_comb begin
    apb_rsp_o.pready = 1'b1;
    apb_rsp_o.pslverr = access & err;
    apb_rsp_o.prdata = access ? rdata : 32'h00000000;
  end

  // Output bytes written by the master
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_byte_q <= '0;
    end else if (wr & out_hit) begin
      out_byte_q[{out_idx, 3'b000} +: 8] <= apb_req_i.pwdata[7:0]; // R3 R4 R16
    end
  end

  // Address bases assigned by the master
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_base_q <= pio_pkg::BASE_RST;
      out_base_q <= pio_pkg::BASE_RST;
    end else if (wr) begin
      if (apb_req_i.paddr == pio_pkg::IN_BASE_OFS) begin
        in_base_q <= apb_req_i.pwdata[7:0]; // R1
      end
      if (apb_req_i.paddr == pio_pkg::OUT_BASE_OFS) begin
        out_base_q <= apb_req_i.pwdata[7:0]; // R1
      end
    end
  end

  // Stack configuration
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_ext_q <= pio_pkg::CFG_EXT_RST;
      cfg_hw_en_q <= pio_pkg::CFG_HW_EN_RST;
    end else if (wr & (apb_req_i.paddr == pio_pkg::CONFIG_OFS)) begin
      cfg_ext_q <= apb_req_i.pwdata[pio_pkg::CFG_EXT_LSB +: pio_pkg::CFG_EXT_W]; // R5
      cfg_hw_en_q <= apb_req_i.pwdata[pio_pkg::CFG_HW_EN_LSB +: NH]; // R13
    end
  end

  // Output drive, absent modules held off
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_drive_q <= '0;
    end else begin
      out_drive_q <= out_byte_q & out_mask; // R4 R5
    end
  end

  assign output_point_o = out_drive_q;

endmodule

/* File: pio_panel_io_chk.sv */
// Port-level assertions for the panel I/O stack
module pio_panel_io_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Watched ports
  input wire pio_pkg::pio_apb_req_t apb_req_i,
  input wire pio_pkg::pio_apb_rsp_t apb_rsp_o,
  input wire logic [pio_pkg::NUM_IN_BITS-1:0] sensed_input_point_i,
  input wire logic [pio_pkg::NUM_MODULES-1:0] input_common_select_high_i,
  input wire logic [pio_pkg::NUM_MODULES-1:0] input_common_select_open_i,
  input wire pio_pkg::pio_hw_phase_t handwheel_phase_i,
  input wire logic [pio_pkg::NUM_OUT_BITS-1:0] output_point_o,
  input wire logic [pio_pkg::NUM_HANDWHEELS-1:0] handwheel_step_o,
  input wire logic [pio_pkg::NUM_HANDWHEELS-1:0] handwheel_up_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc;
  logic [11:0] pa;
  logic [25:0] now_v;
  logic [25:0] d1_q;
  logic [25:0] d2_q;
  logic steady;
  logic inv;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Access cycle decode
  assign acc = apb_req_i.psel && apb_req_i.penable;
  assign pa = apb_req_i.paddr;
  // Module 0 inputs and common, steady for two edges
  assign now_v = {input_common_select_open_i[0], input_common_select_high_i[0],
                  sensed_input_point_i[23:0]};
  assign inv = input_common_select_high_i[0] && !input_common_select_open_i[0];
  always_ff @(posedge core_clk_i) begin
    d1_q <= now_v;
    d2_q <= d1_q;
  end
  assign steady = (d1_q == now_v) && (d2_q == d1_q);
  rdy_always_a: assert property (apb_rsp_o.pready)
    else $error("pready low");
  idle_quiet_a: assert property (!acc |-> apb_rsp_o.prdata == 32'h0 && !apb_rsp_o.pslverr)
    else $error("response outside access");
  unaligned_err_a: assert property (acc && pa[1:0] != 2'h0 |-> apb_rsp_o.pslverr)
    else $error("unaligned access accepted");
  gap_err_a: assert property (acc && pa >= 12'h030 && pa < 12'h040 |-> apb_rsp_o.pslverr)
    else $error("gap address accepted");
  status_ro_a: assert property (acc && apb_req_i.pwrite && pa == 12'h06C |->
    apb_rsp_o.pslverr)
    else $error("status write accepted");
  out_drive_a: assert property (acc && apb_req_i.pwrite && pa == 12'h040 |-> ##2
    output_point_o[7:0] == $past(apb_req_i.pwdata[7:0], 2))
    else $error("output byte not driven");
  first_byte_a: assert property (acc && !apb_req_i.pwrite && pa == 12'h000 && steady |->
    apb_rsp_o.prdata == {24'h0, sensed_input_point_i[7:0] ^ {8{inv}}})
    else $error("first byte wrong");
  fixed_byte_a: assert property (acc && !apb_req_i.pwrite && pa == 12'h004 && steady |->
    apb_rsp_o.prdata == {24'h0, sensed_input_point_i[15:8]})
    else $error("second byte wrong");
  step_pulse_a: assert property (|handwheel_step_o |=> handwheel_step_o == 3'h0)
    else $error("step longer than a cycle");
endmodule

bind pio_panel_io pio_panel_io_chk i_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .sensed_input_point_i(sensed_input_point_i),
  .input_common_select_high_i(input_common_select_high_i),
  .input_common_select_open_i(input_common_select_open_i),
  .handwheel_phase_i(handwheel_phase_i), .output_point_o(output_point_o),
  .handwheel_step_o(handwheel_step_o), .handwheel_up_o(handwheel_up_o));

/* File: pio_ncu_model.sv */
// Control unit model: the single master issuing register transfers
module pio_ncu_model (
  // Clock
  input wire logic core_clk_i,
  // APB master side
  output pio_pkg::pio_apb_req_t apb_req_o,
  input wire pio_pkg::pio_apb_rsp_t apb_rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial apb_req_o = '0;
  // Setup, access held until pready, then release with scrambled lines
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge core_clk_i);
    apb_req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk_i);
    apb_req_o.penable <= 1'b1;
    @(posedge core_clk_i);
    while (apb_rsp_i.pready !== 1'b1) @(posedge core_clk_i);
    q = apb_rsp_i.prdata;
    err = apb_rsp_i.pslverr;
    apb_req_o <= '{psel: 1'b0, penable: 1'b0, pwrite: wr, paddr: ~a, pwdata: ~d};
  endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the panel I/O stack
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i;
  logic reset_n_i;
  pio_pkg::pio_apb_req_t apb_req;
  pio_pkg::pio_apb_rsp_t apb_rsp;
  logic [95:0] pts;
  logic [3:0] com_hi;
  logic [3:0] com_open;
  pio_pkg::pio_hw_phase_t hw_ph;
  logic [63:0] out_pts;
  logic [2:0] step;
  logic [2:0] up;
  logic [31:0] step_n = 32'h0;
  logic last_up = 1'b0;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  // Clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  pio_panel_io i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .apb_req_i(apb_req),
    .apb_rsp_o(apb_rsp), .sensed_input_point_i(pts), .input_common_select_high_i(com_hi),
    .input_common_select_open_i(com_open), .handwheel_phase_i(hw_ph),
    .output_point_o(out_pts), .handwheel_step_o(step), .handwheel_up_o(up));
  pio_ncu_model i_ncu (.core_clk_i(core_clk_i), .apb_req_o(apb_req), .apb_rsp_i(apb_rsp));
  // Step monitor of wheel 0 and hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (step[0] === 1'b1) begin
      step_n <= step_n + 32'h1;
      last_up <= up[0];
    end
    if (cyc == 90000) begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    i_ncu.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    logic [31:0] q;
    logic e;
    i_ncu.xfer(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, err});
  endtask
  task automatic t_regs();
    rd(12'h068, 32'h0000_0070);
    rd(12'h06C, 32'h0000_02B0);
    wr(12'h060, 32'h0000_00A5, 1'b0);
    rd(12'h060, 32'h0000_00A5);
    wr(12'h064, 32'h0000_005A, 1'b0);
    rd(12'h064, 32'h0000_005A);
    wr(12'h06C, 32'h0000_0003, 1'b1);
    wr(12'h030, 32'h0, 1'b1);
    wr(12'h041, 32'h0, 1'b1);
    wr(12'h000, 32'h0, 1'b1);
  endtask
  task automatic t_absent();
    wr(12'h048, 32'h0000_00AB, 1'b0);
    repeat (3) @(posedge core_clk_i);
    chk({24'h0, out_pts[23:16]}, 32'h0);
    rd(12'h00C, 32'h0);
    wr(12'h068, 32'h0000_0071, 1'b0);
    repeat (3) @(posedge core_clk_i);
    chk({24'h0, out_pts[23:16]}, 32'h0000_00AB);
  endtask
  task automatic t_inputs();
    logic [7:0] v;
    wr(12'h068, 32'h0000_0073, 1'b0);
    rd(12'h06C, 32'h0000_02B7);
    for (int i = 0; i < 12; i++) begin
      v = pts[i*8 +: 8];
      if (i % 3 == 0 && com_hi[i/3] && !com_open[i/3]) v = ~v;
      rd(12'(4 * i), {24'h0, v});
    end
  endtask
  task automatic t_outputs();
    logic [63:0] exp;
    for (int j = 0; j < 8; j++) begin
      exp[j*8 +: 8] = 8'(j * 37 + 1);
      wr(12'h040 + 12'(4 * j), {24'h0, exp[j*8 +: 8]}, 1'b0);
    end
    repeat (3) @(posedge core_clk_i);
    chk(out_pts[31:0], exp[31:0]);
    chk(out_pts[63:32], exp[63:32]);
    rd(12'h044, {24'h0, exp[15:8]});
  endtask
  // Four quarter moves on all wheels, each held longer than 50 us
  task automatic quarters(input logic [7:0] seq);
    for (int k = 3; k >= 0; k--) begin
      hw_ph <= {{3{seq[2*k+1]}}, {3{seq[2*k]}}};
      repeat (5500) @(posedge core_clk_i);
    end
  endtask
  task automatic t_wheel();
    quarters(8'hB4);
    chk(step_n, 32'h1);
    chk({31'h0, last_up}, 32'h1);
    rd(12'h070, 32'h1);
    rd(12'h078, 32'h1);
    wr(12'h068, 32'h0000_0033, 1'b0);
    quarters(8'h78);
    chk(step_n, 32'h2);
    chk({31'h0, last_up}, 32'h0);
    rd(12'h074, 32'h0);
    rd(12'h078, 32'h1);
    wr(12'h068, 32'h0000_0070, 1'b0);
    quarters(8'hB4);
    chk(step_n, 32'h2);
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset_n_i = 1'b0;
    for (int i = 0; i < 12; i++) pts[i*8 +: 8] = 8'(i * 19);
    com_hi = 4'hB;
    com_open = 4'h2;
    hw_ph = '0;
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_absent();
    t_inputs();
    t_outputs();
    t_wheel();
    report_and_stop();
  end
endmodule
